// file: verilog/brk_logic.sv
// Purpose: break-request logic of the in-circuit emulator
// Assumes: evaluation chip status inputs are synchronous to ref_clk
// Notes:   a break request ends real-time emulation the next cycle
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module brk_logic
    import brk_pkg::*;
#(
    parameter int         ADDR_W   = 16,
    parameter logic [7:0] ROM_SIZE = ROMSIZE_RST
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        fetch_valid,
    input  wire logic        fetch_second_word,
    input  wire logic        table_rd,
    input  wire logic [15:0] table_addr,
    input  wire logic        instr_done,
    input  wire logic [1:0]  instr_cycles,
    input  wire logic        second_machine_state,
    input  wire logic        halt_exec,
    input  wire logic        call_stack_fault,
    input  wire logic        register_stack_fault,
    input  wire logic        trace_wr,
    input  wire logic        probe_break_input,
    output logic             run_realtime,
    output logic             run_step,
    output logic             break_req,
    output logic             halt_release,
    output logic             chip_reset_n,
    output logic             time_base_counter_stop,
    output logic             watchdog_timer_gate,
    output logic             code_wr,
    output logic      [15:0] code_wr_addr,
    output logic      [15:0] code_wr_data,
    output logic             xmem_bank_hold
);
    initial begin
        if (ADDR_W != 16)
            $error("code space must be 16 address bits");
    end

    localparam int CODE_WORDS = 1 << ADDR_W;
    localparam int TRACE_W_C  = 13;

    typedef struct packed {
        emu_state_t          st;
        logic [CTL_W-1:0]    ctrl;
        logic [SRC_W-1:0]    pend;
        logic [7:0]          romsize;
        logic [15:0]         bp_ptr;
        logic [7:0]          code_hi;
        logic [15:0]         test_lo;
        logic [15:0]         test_hi;
        logic                probe_q;
        logic                ext_arm;
        logic                ext_req;
        logic                s2_q;
        logic                narea_arm;
        logic [3:0]          rst_cnt;
        logic [15:0]         rdata;
        logic                brk;
        logic                hrel;
        logic                cwr;
        logic [15:0]         cwa;
        logic [15:0]         cwd;
    } state_t;

    state_t                  s_r;
    state_t                  s_nxt;
    logic [CODE_WORDS-1:0]   bp_bits_r;
    logic [TRACE_W_C-1:0]    trace_ptr;
    logic [23:0]             cyc_count;
    logic                    trace_ovf;
    logic                    cyc_ovf;
    logic                    rt;

    // absent-code test: beyond ROM size or inside test data region, never while expansion is on
    function automatic logic absent(input logic [15:0] a,
                                    input state_t s);
        logic lim;
        lim = (a[15:8] >= s.romsize);
        if (s.ctrl[CTL_EXPAND])
            absent = 1'b0;
        else
            absent = lim || (a >= s.test_lo && a <= s.test_hi);
    endfunction : absent

    assign rt = (s_r.st == ST_RUN);

    brk_counters #(
        .TRACE_W (TRACE_W_C),
        .CYC_W   (24)
    ) u_cnt (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .run          (rt),
        .trace_wr     (trace_wr),
        .instr_done   (instr_done),
        .instr_cycles (instr_cycles),
        .trace_ptr    (trace_ptr),
        .cyc_count    (cyc_count),
        .trace_ovf    (trace_ovf),
        .cyc_ovf      (cyc_ovf)
    );

    // breakpoint bit store, one bit per code word
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            bp_bits_r <= '0;
        else if (reg_wr && reg_addr == REG_BP_DATA)
            bp_bits_r[s_r.bp_ptr] <= reg_wdata[0];
    end

    // next state: register port, break sources, run control
    always_comb begin
        logic [SRC_W-1:0] hit;
        logic             ctl_wr;
        hit          = '0;
        ctl_wr       = reg_wr && reg_addr == REG_CTRL;
        s_nxt        = s_r;
        s_nxt.probe_q = probe_break_input;
        s_nxt.s2_q   = second_machine_state;
        s_nxt.brk    = 1'b0;
        s_nxt.hrel   = 1'b0;
        s_nxt.cwr    = 1'b0;
        s_nxt.rdata  = 16'h0000;
        if (s_r.rst_cnt != 4'h0)
            s_nxt.rst_cnt = s_r.rst_cnt - 4'h1;

        // conditional sources only in real-time run
        if (rt) begin
            hit[SRC_BP] = s_r.ctrl[CTL_BP] && fetch_valid
                && !fetch_second_word && !table_rd
                && bp_bits_r[fetch_addr];
            hit[SRC_TRACE] = s_r.ctrl[CTL_TRACE] && trace_ovf;
            hit[SRC_CYC] = s_r.ctrl[CTL_CYC] && cyc_ovf;
            // request taken as second state starts, accepted as it ends
            hit[SRC_EXT] = s_r.ext_req && s_r.s2_q
                && !second_machine_state;
            if (hit[SRC_EXT])
                s_nxt.ext_req = 1'b0;
            if (s_r.ext_arm && second_machine_state && !s_r.s2_q) begin
                s_nxt.ext_req = 1'b1;
                s_nxt.ext_arm = 1'b0;
            end
            // a rising probe edge arms; a late edge waits for next state
            if (s_r.ctrl[CTL_EXT] && probe_break_input && !s_r.probe_q)
                s_nxt.ext_arm = 1'b1;
            hit[SRC_HALT] = s_r.ctrl[CTL_HALT] && halt_exec;
            hit[SRC_CSTK] = s_r.ctrl[CTL_CSTK] && call_stack_fault;
            hit[SRC_RSTK] = s_r.ctrl[CTL_RSTK]
                && register_stack_fault;
        end
        // forced breaks: table read at once, fetch after it executes
        if (s_r.st != ST_IDLE) begin
            if (table_rd && absent(table_addr, s_r))
                hit[SRC_NAREA] = 1'b1;
            if (s_r.narea_arm && instr_done) begin
                hit[SRC_NAREA] = 1'b1;
                s_nxt.narea_arm = 1'b0;
            end
            // a new absent fetch wins over the clear
            if (fetch_valid && absent(fetch_addr, s_r))
                s_nxt.narea_arm = 1'b1;
        end
        // halt returns at once; release it each time
        if (halt_exec)
            s_nxt.hrel = 1'b1;

        // register writes
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                s_nxt.ctrl = reg_wdata[CTL_W-1:0];
                if (reg_wdata[CTL_EXPAND] != s_r.ctrl[CTL_EXPAND])
                    s_nxt.rst_cnt = 4'(RESET_CYC);
            end else if (reg_addr == REG_ROMSIZE) begin
                s_nxt.romsize = reg_wdata[7:0];
            end else if (reg_addr == REG_BP_ADDR) begin
                s_nxt.bp_ptr = reg_wdata;
            end else if (reg_addr == REG_CODE_HI) begin
                s_nxt.code_hi = reg_wdata[7:0];
            end else if (reg_addr == REG_CODE_LO) begin
                s_nxt.cwr = 1'b1;
                s_nxt.cwa = s_r.bp_ptr;
                s_nxt.cwd = {s_r.code_hi, reg_wdata[7:0]};
            end else if (reg_addr == REG_TEST_LO) begin
                s_nxt.test_lo = reg_wdata;
            end else if (reg_addr == REG_TEST_HI) begin
                s_nxt.test_hi = reg_wdata;
            end else if (reg_addr == REG_RUN) begin
                if (reg_wdata[RUN_USER]) begin
                    hit[SRC_USER] = 1'b1;
                    s_nxt.hrel = 1'b1;
                end else if (reg_wdata[RUN_START] && s_r.st == ST_IDLE) begin
                    s_nxt.st = ST_RUN;
                    // resume drops old counter requests
                    s_nxt.pend[SRC_TRACE] = 1'b0;
                    s_nxt.pend[SRC_CYC]   = 1'b0;
                end else if (reg_wdata[RUN_STEP] && s_r.st == ST_IDLE) begin
                    s_nxt.st = ST_STEP;
                end
            end
        end
        if (s_r.st == ST_STEP && instr_done)
            s_nxt.st = ST_IDLE;

        // accept any request: stop emulation, latch cause
        if (|hit) begin
            s_nxt.pend = s_nxt.pend | hit;
            s_nxt.brk  = 1'b1;
            s_nxt.st   = ST_IDLE;
        end
        if (ctl_wr && s_r.st == ST_IDLE)
            s_nxt.pend = hit; // clear causes while stopped

        // read data stands the cycle after the strobe
        if (reg_rd) begin
            if (reg_addr == REG_CTRL)
                s_nxt.rdata = {6'h00, s_r.ctrl};
            else if (reg_addr == REG_STATUS)
                s_nxt.rdata = {4'h0, s_r.rst_cnt != 4'h0, s_r.st, s_r.pend};
            else if (reg_addr == REG_ROMSIZE)
                s_nxt.rdata = {8'h00, s_r.romsize};
            else if (reg_addr == REG_CYC_LO)
                s_nxt.rdata = cyc_count[15:0];
            else if (reg_addr == REG_CYC_HI)
                s_nxt.rdata = {8'h00, cyc_count[23:16]};
            else if (reg_addr == REG_TRACE)
                s_nxt.rdata = {3'h0, trace_ptr};
            else if (reg_addr == REG_BP_ADDR)
                s_nxt.rdata = s_r.bp_ptr;
            else if (reg_addr == REG_BP_DATA)
                s_nxt.rdata = {15'h0000, bp_bits_r[s_r.bp_ptr]};
            else if (reg_addr == REG_CODE_HI)
                s_nxt.rdata = {8'h00, s_r.code_hi};
            else if (reg_addr == REG_TEST_LO)
                s_nxt.rdata = s_r.test_lo;
            else if (reg_addr == REG_TEST_HI)
                s_nxt.rdata = s_r.test_hi;
            else
                s_nxt.rdata = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_r         <= '0;
            s_r.st      <= ST_IDLE;
            s_r.ctrl    <= CTRL_RST;
            s_r.romsize <= ROM_SIZE;
            s_r.test_lo <= TEST_LO_RST;
            s_r.test_hi <= TEST_HI_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs from flip-flops or simple decodes of them
    assign reg_rdata              = s_r.rdata;
    assign run_realtime           = rt;
    assign run_step               = (s_r.st == ST_STEP);
    assign break_req              = s_r.brk;
    assign halt_release           = s_r.hrel;
    assign chip_reset_n           = (s_r.rst_cnt == 4'h0);
    assign time_base_counter_stop = s_r.ctrl[CTL_TBC];
    assign watchdog_timer_gate    = s_r.ctrl[CTL_WDT];
    assign code_wr                = s_r.cwr;
    assign code_wr_addr           = s_r.cwa;
    assign code_wr_data           = s_r.cwd;
    // no bank select: external accesses keep the program's bank
    assign xmem_bank_hold         = 1'b1;

    // assertions
    break_stops_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_r.brk |-> s_r.st == ST_IDLE)
        else $error("break did not stop emulation");
    step_no_cond_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_r.st == ST_STEP && halt_exec && !(reg_wr && reg_addr == REG_RUN))
        |=> !s_r.pend[SRC_HALT] || $past(s_r.pend[SRC_HALT]))
        else $error("conditional break raised in single step");
    halt_brk_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rt && s_r.ctrl[CTL_HALT] && halt_exec) |=> s_r.brk
        && s_r.pend[SRC_HALT])
        else $error("halt break missing");
    halt_rel_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        halt_exec |=> halt_release)
        else $error("halt not released");
    second_word_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rt && fetch_valid && fetch_second_word && !halt_exec
        && !trace_ovf && !cyc_ovf && !s_r.ext_req && !call_stack_fault
        && !register_stack_fault && !table_rd && !s_r.narea_arm
        && !absent(fetch_addr, s_r) && !reg_wr)
        |=> !s_r.brk)
        else $error("second word breakpoint broke");
    resume_clr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_wr && reg_addr == REG_RUN && reg_wdata == 16'h0001
        && s_r.st == ST_IDLE) |=> !s_r.pend[SRC_CYC])
        else $error("cycle request not cleared on resume");
    expand_rst_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_wr && reg_addr == REG_CTRL
        && reg_wdata[CTL_EXPAND] != s_r.ctrl[CTL_EXPAND])
        |=> !chip_reset_n [*4])
        else $error("expansion change did not reset chip");
    user_brk_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_wr && reg_addr == REG_RUN && reg_wdata[RUN_USER])
        |=> break_req && halt_release && s_r.st == ST_IDLE)
        else $error("user break not immediate");
    cv_bp: cover property (@(posedge ref_clk) s_r.brk && s_r.pend[SRC_BP]);
    cv_ext: cover property (@(posedge ref_clk) s_r.brk && s_r.pend[SRC_EXT]);
    cv_narea: cover property (@(posedge ref_clk)
        s_r.brk && s_r.pend[SRC_NAREA]);
endmodule : brk_logic

// file: shared/brk_pkg.sv
// Purpose: shared constants and types for the emulator break-request logic
// Assumes: one clock, synchronous active-low reset
// Notes:   register offsets address the plain register port
package brk_pkg;
    // register offsets (word index on the plain port)
    localparam logic [3:0] REG_CTRL     = 4'h0; // enables and options
    localparam logic [3:0] REG_STATUS   = 4'h1; // pending requests, run state
    localparam logic [3:0] REG_ROMSIZE  = 4'h2; // enabled code size, words/256
    localparam logic [3:0] REG_CYC_LO   = 4'h3; // cycle counter bits 15:0
    localparam logic [3:0] REG_CYC_HI   = 4'h4; // cycle counter bits 23:16
    localparam logic [3:0] REG_TRACE    = 4'h5; // trace write pointer
    localparam logic [3:0] REG_BP_ADDR  = 4'h6; // breakpoint address pointer
    localparam logic [3:0] REG_BP_DATA  = 4'h7; // breakpoint bit at pointer
    localparam logic [3:0] REG_CODE_HI  = 4'h8; // upper code byte staging
    localparam logic [3:0] REG_CODE_LO  = 4'h9; // lower byte, writes pair
    localparam logic [3:0] REG_TEST_LO  = 4'ha; // test data region start
    localparam logic [3:0] REG_TEST_HI  = 4'hb; // test data region end
    localparam logic [3:0] REG_RUN      = 4'hc; // start / user break command
    // control register bit positions
    localparam int CTL_BP     = 0;
    localparam int CTL_TRACE  = 1;
    localparam int CTL_CYC    = 2;
    localparam int CTL_EXT    = 3;
    localparam int CTL_HALT   = 4;
    localparam int CTL_CSTK   = 5;
    localparam int CTL_RSTK   = 6;
    localparam int CTL_EXPAND = 7;
    localparam int CTL_TBC    = 8;
    localparam int CTL_WDT    = 9;
    localparam int CTL_W      = 10;
    // run command bits
    localparam int RUN_START  = 0;
    localparam int RUN_USER   = 1;
    localparam int RUN_STEP   = 2;
    // break cause codes, one bit each in the pending field
    localparam int SRC_BP     = 0;
    localparam int SRC_TRACE  = 1;
    localparam int SRC_CYC    = 2;
    localparam int SRC_EXT    = 3;
    localparam int SRC_HALT   = 4;
    localparam int SRC_CSTK   = 5;
    localparam int SRC_RSTK   = 6;
    localparam int SRC_NAREA  = 7;
    localparam int SRC_USER   = 8;
    localparam int SRC_W      = 9;
    // reset values
    localparam logic [9:0]  CTRL_RST    = 10'h000;
    localparam logic [15:0] TEST_LO_RST = 16'hffff;
    localparam logic [15:0] TEST_HI_RST = 16'h0000;
    localparam logic [7:0]  ROMSIZE_RST = 8'h20; // 8 KW default
    // timing: one machine cycle at 25 MHz is one clock here
    localparam int CLK_NS    = 40;
    localparam int RESET_NS  = 160;  // evaluation chip reset pulse
    localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
    // emulation state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_STEP = 2'b10
    } emu_state_t;
endpackage : brk_pkg

// file: verilog/brk_counters.sv
// Purpose: trace pointer and cycle counter with overflow pulses
// Assumes: inputs synchronous to ref_clk
// Notes:   counting only while run is high
`timescale 1ns/10ps
module brk_counters
    import brk_pkg::*;
#(
    parameter int TRACE_W = 13,
    parameter int CYC_W   = 24
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic               run,
    input  wire logic               trace_wr,
    input  wire logic               instr_done,
    input  wire logic [1:0]         instr_cycles,
    output logic      [TRACE_W-1:0] trace_ptr,
    output logic      [CYC_W-1:0]   cyc_count,
    output logic                    trace_ovf,
    output logic                    cyc_ovf
);
    initial begin
        if (TRACE_W < 2 || CYC_W < 3)
            $error("counter widths too small");
    end

    typedef struct packed {
        logic [TRACE_W-1:0] tp;
        logic [CYC_W-1:0]   cc;
        logic               tov;
        logic               cov;
    } cnt_t;

    cnt_t cnt_r;
    cnt_t cnt_nxt;
    logic [CYC_W:0] cc_sum;

    // counters wrap; the carry out marks overflow
    always_comb begin
        cnt_nxt     = cnt_r;
        cnt_nxt.tov = 1'b0;
        cnt_nxt.cov = 1'b0;
        cc_sum      = {1'b0, cnt_r.cc} + {{(CYC_W-1){1'b0}}, instr_cycles};
        if (run && trace_wr) begin
            cnt_nxt.tp  = cnt_r.tp + 1'b1;
            cnt_nxt.tov = &cnt_r.tp;
        end
        if (run && instr_done) begin
            // leftover after wrap is 0..cycles-1 of the instruction
            cnt_nxt.cc  = cc_sum[CYC_W-1:0];
            cnt_nxt.cov = cc_sum[CYC_W];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign trace_ptr = cnt_r.tp;
    assign cyc_count = cnt_r.cc;
    assign trace_ovf = cnt_r.tov;
    assign cyc_ovf   = cnt_r.cov;

    property wrap_rest_p;
        @(posedge ref_clk) disable iff (!nrst)
        cnt_r.cov |-> (cnt_r.cc >= 1 && cnt_r.cc <= 3);
    endproperty
    cyc_wrap_a: assert property (wrap_rest_p)
        else $error("cycle counter remainder out of range");
endmodule : brk_counters

// file: tb/chip_model.sv
// Purpose: evaluation chip stand-in that runs one instruction per call
// Assumes: called from the bench; every change lands right after an edge
// Notes:   a released address bus shows the inverse of its last value
`timescale 1ns/10ps
module chip_model
    import brk_pkg::*;
(
    input  wire logic        ref_clk,
    output logic      [15:0] fetch_addr,
    output logic             fetch_valid,
    output logic             fetch_second_word,
    output logic             instr_done,
    output logic      [1:0]  instr_cycles,
    output logic             second_machine_state,
    output logic      [2:0]  evt,
    output logic             trace_wr
);
    // idle bus at time zero
    initial begin
        {fetch_addr, fetch_valid, fetch_second_word, instr_done} = '0;
        {instr_cycles, second_machine_state, evt, trace_wr} = '0;
    end
    // fetch, second state with event pulses (halt, call, register), done
    task automatic exec(input logic [15:0] a, input logic sw,
                        input logic [2:0] ev);
        @(posedge ref_clk);
        fetch_addr        <= a;
        fetch_valid       <= 1'b1;
        fetch_second_word <= sw;
        @(posedge ref_clk);
        fetch_valid          <= 1'b0;
        fetch_addr           <= ~a; // released bus, not a stale copy
        second_machine_state <= 1'b1;
        evt                  <= ev;
        trace_wr             <= 1'b1;
        @(posedge ref_clk);
        second_machine_state <= 1'b0;
        evt                  <= 3'h0;
        trace_wr             <= 1'b0;
        instr_done           <= 1'b1;
        instr_cycles         <= 2'h1;
        @(posedge ref_clk);
        instr_done <= 1'b0;
    endtask : exec
    // back-to-back trace entries, one per clock
    task automatic trace_burst(input int n);
        @(posedge ref_clk);
        trace_wr <= 1'b1;
        repeat (n) @(posedge ref_clk);
        trace_wr <= 1'b0;
    endtask : trace_burst
endmodule : chip_model

// file: tb/tb.sv
// Purpose: self-checking bench for the break-request logic
// Assumes: register port strobes one cycle, read data one cycle later
// Notes:   break pulses are counted and code writes caught on the falling edge
`timescale 1ns/10ps
module tb
    import brk_pkg::*;
;
    logic        ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
    logic        probe_break_input = 0, break_req, chip_reset_n, code_wr;
    logic        time_base_counter_stop, watchdog_timer_gate, xmem_bank_hold;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, fetch_addr;
    logic [15:0] code_wr_addr, code_wr_data, cw_a, cw_d;
    logic        fetch_valid, fetch_second_word, instr_done;
    logic        second_machine_state, trace_wr, table_rd = 0;
    logic        run_realtime, run_step, halt_release;
    logic [15:0] table_addr = 16'h0000;
    logic [1:0]  instr_cycles;
    logic [2:0]  evt;
    logic [31:0] r = 32'h7dea12fa;
    int          n_fail = 0, num_checks = 0, n_brk = 0, n_rel = 0, i;
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    chip_model m (.ref_clk, .fetch_addr, .fetch_valid, .fetch_second_word,
        .instr_done, .instr_cycles, .second_machine_state, .evt, .trace_wr);
    brk_logic dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .fetch_addr, .fetch_valid, .fetch_second_word,
        .table_rd, .table_addr, .instr_done, .instr_cycles,
        .second_machine_state, .halt_exec(evt[0]), .call_stack_fault(evt[1]),
        .register_stack_fault(evt[2]), .trace_wr, .probe_break_input,
        .run_realtime, .run_step, .break_req, .halt_release,
        .chip_reset_n, .time_base_counter_stop, .watchdog_timer_gate,
        .code_wr, .code_wr_addr, .code_wr_data, .xmem_bank_hold);
    // count break pulses and catch code word writes where settled
    always @(negedge ref_clk) begin
        if (break_req === 1'b1) n_brk++;
        if (halt_release === 1'b1) n_rel++;
        if (code_wr === 1'b1) begin
            cw_a = code_wr_addr;
            cw_d = code_wr_data;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // clear pending causes while idle, then start real-time run
    task automatic go(input logic [15:0] ctl);
        wr(REG_CTRL, ctl);
        wr(REG_RUN, 16'h0001);
        n_brk = 0;
        n_rel = 0;
    endtask : go
    // expect one break pulse (or none) and exactly that pending cause
    task automatic fin(input int src, input int hit);
        repeat (8) @(posedge ref_clk);
        chk(16'(n_brk), 16'(hit));
        if (hit == 1) begin
            chk(16'(run_realtime), 16'h0000);
            rd(REG_STATUS, 16'(1 << src));
        end
    endtask : fin
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // hang guard, about twice the nine thousand cycles the tests need
    initial begin
        #800000;
        n_fail++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(REG_STATUS, 16'h0000);
        rd(REG_ROMSIZE, 16'h0020);
        chk(16'(xmem_bank_hold), 16'h0001);
        wr(REG_BP_ADDR, 16'h0020);
        wr(REG_CODE_HI, 16'h00ab);
        wr(REG_CODE_LO, 16'h00cd);
        repeat (2) @(posedge ref_clk);
        chk(cw_a, 16'h0020);
        chk(cw_d, 16'habcd);
        // trace pointer: 8191 entries fill it, the 8192nd overflows
        go(16'(1 << CTL_TRACE));
        m.trace_burst(8191);
        fin(SRC_TRACE, 0);
        rd(REG_TRACE, 16'h1fff);
        m.trace_burst(1);
        fin(SRC_TRACE, 1);
        // plain resume drops the trace request
        wr(REG_RUN, 16'h0001);
        n_brk = 0;
        rd(REG_STATUS, 16'h0200);
        wr(REG_RUN, 16'h0002);
        fin(SRC_USER, 1);
        // breakpoint: second word never hits, first word does
        wr(REG_BP_ADDR, 16'h0010);
        wr(REG_BP_DATA, 16'h0001);
        r = lfsr(r);
        go(16'(1 << CTL_BP));
        m.exec(16'h0010, 1'b1, 3'h0);
        m.exec(16'h0100 | 16'(r[11:0]), 1'b0, 3'h0);
        fin(SRC_BP, 0);
        m.exec(16'h0010, 1'b0, 3'h0);
        fin(SRC_BP, 1);
        rd(REG_CYC_LO, 16'h0002);
        // halt, call stack, register stack each with its own enable
        for (i = 0; i < 3; i++) begin
            r = lfsr(r);
            go(16'(1 << (CTL_HALT + i)));
            m.exec(16'h0100 | 16'(r[11:0]), 1'b0, 3'(1 << i));
            fin(SRC_HALT + i, 1);
        end
        // single step ignores an enabled halt and stops after one
        wr(REG_CTRL, 16'(1 << CTL_HALT));
        wr(REG_RUN, 16'h0004);
        n_brk = 0;
        n_rel = 0;
        #1 chk(16'(run_step), 16'h0001);
        m.exec(16'h0200, 1'b0, 3'h1);
        fin(SRC_HALT, 0);
        chk(16'(n_rel), 16'h0001);
        rd(REG_STATUS, 16'h0000);
        // all enables off: events ignored, keyboard break still ends run
        go(16'h0000);
        m.exec(16'h0200, 1'b0, 3'h7);
        fin(SRC_HALT, 0);
        wr(REG_RUN, 16'h0002);
        fin(SRC_USER, 1);
        chk(16'(n_rel), 16'h0002);
        // probe rising edge
        go(16'(1 << CTL_EXT));
        probe_break_input <= 1'b1;
        m.exec(16'h0300, 1'b0, 3'h0);
        fin(SRC_EXT, 1);
        probe_break_input <= 1'b0;
        // fetch from absent code breaks with no enable
        r = lfsr(r);
        go(16'h0000);
        m.exec(16'h2000 | 16'(r[15:0]), 1'b0, 3'h0);
        fin(SRC_NAREA, 1);
        // table reads: breakpoint there ignored, absent address forces
        go(16'(1 << CTL_BP));
        @(posedge ref_clk);
        table_rd   <= 1'b1;
        table_addr <= 16'h0010;
        @(posedge ref_clk);
        table_addr <= 16'h3000 | 16'(r[11:0]);
        @(posedge ref_clk);
        table_rd <= 1'b0;
        fin(SRC_NAREA, 1);
        // test data region counts as absent code
        wr(REG_TEST_LO, 16'h0400);
        wr(REG_TEST_HI, 16'h04ff);
        go(16'h0000);
        m.exec(16'h0400 | 16'(r[7:0]), 1'b0, 3'h0);
        fin(SRC_NAREA, 1);
        // expansion resets the chip and removes the absent region
        wr(REG_CTRL, 16'h0380);
        @(posedge ref_clk);
        #1 chk(16'(chip_reset_n), 16'h0000);
        chk(16'(time_base_counter_stop), 16'h0001);
        chk(16'(watchdog_timer_gate), 16'h0001);
        repeat (8) @(posedge ref_clk);
        chk(16'(chip_reset_n), 16'h0001);
        go(16'h0380);
        m.exec(16'h2000 | 16'(r[31:16]), 1'b0, 3'h0);
        fin(SRC_NAREA, 0);
        wr(REG_RUN, 16'h0002);
        fin(SRC_USER, 1);
        stop_test();
    end
endmodule : tb
